/* bst_pkg.sv */
// Constants, tap states and layout of the boundary test operations
package bst_pkg;

  // ----------------------------------------------------------------
  // Chain layout
  // ----------------------------------------------------------------
  localparam int N_DATA  = 36;
  localparam int N_HALF  = 18;
  localparam int N_GRP   = 9;
  localparam int N_CHAIN = 52;
  localparam int OE_LSB  = 48;
  localparam int CTL_LSB = 36;

  // ----------------------------------------------------------------
  // Instructions and capture values
  // ----------------------------------------------------------------
  localparam logic [7:0] IR_CAPTURE   = 8'h81;
  localparam logic [7:0] INSTR_BYPASS = 8'hFF;
  localparam logic [7:0] INSTR_RUN    = 8'h09;
  localparam logic [7:0] INSTR_BSCAN  = 8'h82;
  localparam logic [7:0] INSTR_OPSCAN = 8'h0E;

  // ----------------------------------------------------------------
  // Operation select and direction
  // ----------------------------------------------------------------
  localparam logic [1:0] OPL_TOGGLE    = 2'h0;
  localparam logic [1:0] OPL_PATTERN   = 2'h1;
  localparam logic [1:0] OPL_SIGNATURE = 2'h2;
  localparam int         OPSEL_COUNT   = 2;
  localparam logic [2:0] OPSEL_RESET   = 3'h0;
  // dir bits: 0 byte1 A, 1 byte2 A, 2 byte1 B, 3 byte2 B
  localparam logic [3:0] DIR_RESET     = 4'h0;
  localparam logic [3:0] DIR_A_IN      = 4'hC;
  localparam logic [3:0] DIR_B_IN      = 4'h3;

  // ----------------------------------------------------------------
  // Feedback taps, x^36+x^25+1 and x^18+x^11+1
  // ----------------------------------------------------------------
  localparam logic [35:0] TAPS36 = 36'h8_0100_0000;
  localparam logic [17:0] TAPS18 = 18'h2_0400;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_CHAIN_LO  = 8'h08;
  localparam logic [7:0]  REG_CHAIN_HI  = 8'h0C;
  localparam logic [7:0]  REG_SHADOW_LO = 8'h10;
  localparam logic [51:0] CHAIN_RESET   = 52'h0_0000_0000_0000;

  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
    TAP_SH_DR = 4'h6, TAP_EX1_DR = 4'h7, TAP_PA_DR = 4'h5, TAP_EX2_DR = 4'h4,
    TAP_UP_DR = 4'hC, TAP_SEL_IR = 4'hD, TAP_CAP_IR = 4'hF, TAP_SH_IR = 4'hE,
    TAP_EX1_IR = 4'hA, TAP_PA_IR = 4'hB, TAP_EX2_IR = 4'h9, TAP_UP_IR = 4'h8
  } bst_tap_e;

endpackage

/* bst_sync.sv */
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/100ps
module bst_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

/* bst_lfsr_step.sv */
// One step of a parallel-input linear-feedback shift register
`timescale 1ns/100ps
module bst_lfsr_step #(
  parameter int         W    = 18,
  parameter logic [W-1:0] TAPS = '1
) (
  // Current value and parallel input
  input  wire logic [W-1:0] cur,
  input  wire logic [W-1:0] din,
  // Next value
  output logic      [W-1:0] nxt
);

  // Fibonacci feedback into bit 0, parallel input folded on every bit
  always_comb begin
    nxt = {cur[W-2:0], ^(cur & TAPS)} ^ din;
  end

endmodule

/* bst_top.sv */
// Boundary test operations, test port and register slave
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/100ps
module bst_top (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Test port
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  output logic             tdo,
  output logic             tdo_oe,
  // Data I/O pins, cells 0..17 side A, 18..35 side B
  input  wire logic [35:0] pin_in,
  output logic      [35:0] pin_out,
  output logic      [35:0] pin_oe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bst_pkg::bst_tap_e tap;
    logic [7:0]        ir;
    logic [7:0]        instr;
    logic [2:0]        opsel;
    logic [2:0]        opsh;
    logic              byp;
    logic [51:0]       chain;
    logic [51:0]       shadow;
    logic              ran;
    logic              tck_d;
    logic              tdo;
    logic              tdo_oe;
    logic [35:0]       pin_oe;
    logic [3:0]        dir;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } bst_state_s;

  bst_state_s r;
  bst_state_s next_r;

  logic [38:0] sync_q;
  logic        tck_s;
  logic        tms_s;
  logic        tdi_s;
  logic [35:0] pin_s;

  // Pins and test port cross in together, so their skew stays equal
  bst_sync #(.W(39)) u_sync (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .d     ({tck, tms, tdi, pin_in}),
    .q     (sync_q)
  );
  assign {tck_s, tms_s, tdi_s, pin_s} = sync_q;

  // ----------------------------------------------------------------
  // Arrangement by direction
  // ----------------------------------------------------------------
  function automatic logic [35:0] ord(input logic [35:0] v, input logic sw);
    ord = sw ? {v[bst_pkg::N_HALF-1:0], v[bst_pkg::N_DATA-1:bst_pkg::N_HALF]} : v;
  endfunction

  function automatic logic [35:0] oe_expand(input logic [51:0] s);
    oe_expand = {{bst_pkg::N_GRP{s[bst_pkg::OE_LSB+3]}}, {bst_pkg::N_GRP{s[bst_pkg::OE_LSB+2]}},
                 {bst_pkg::N_GRP{s[bst_pkg::OE_LSB+1]}}, {bst_pkg::N_GRP{s[bst_pkg::OE_LSB]}}};
  endfunction

  function automatic bst_pkg::bst_tap_e tap_next(input bst_pkg::bst_tap_e s, input logic m);
    case (s)
      bst_pkg::TAP_RESET:  tap_next = m ? bst_pkg::TAP_RESET  : bst_pkg::TAP_IDLE;
      bst_pkg::TAP_IDLE:   tap_next = m ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_IDLE;
      bst_pkg::TAP_SEL_DR: tap_next = m ? bst_pkg::TAP_SEL_IR : bst_pkg::TAP_CAP_DR;
      bst_pkg::TAP_CAP_DR: tap_next = m ? bst_pkg::TAP_EX1_DR : bst_pkg::TAP_SH_DR;
      bst_pkg::TAP_SH_DR:  tap_next = m ? bst_pkg::TAP_EX1_DR : bst_pkg::TAP_SH_DR;
      bst_pkg::TAP_EX1_DR: tap_next = m ? bst_pkg::TAP_UP_DR  : bst_pkg::TAP_PA_DR;
      bst_pkg::TAP_PA_DR:  tap_next = m ? bst_pkg::TAP_EX2_DR : bst_pkg::TAP_PA_DR;
      bst_pkg::TAP_EX2_DR: tap_next = m ? bst_pkg::TAP_UP_DR  : bst_pkg::TAP_SH_DR;
      bst_pkg::TAP_UP_DR:  tap_next = m ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_IDLE;
      bst_pkg::TAP_SEL_IR: tap_next = m ? bst_pkg::TAP_RESET  : bst_pkg::TAP_CAP_IR;
      bst_pkg::TAP_CAP_IR: tap_next = m ? bst_pkg::TAP_EX1_IR : bst_pkg::TAP_SH_IR;
      bst_pkg::TAP_SH_IR:  tap_next = m ? bst_pkg::TAP_EX1_IR : bst_pkg::TAP_SH_IR;
      bst_pkg::TAP_EX1_IR: tap_next = m ? bst_pkg::TAP_UP_IR  : bst_pkg::TAP_PA_IR;
      bst_pkg::TAP_PA_IR:  tap_next = m ? bst_pkg::TAP_EX2_IR : bst_pkg::TAP_PA_IR;
      bst_pkg::TAP_EX2_IR: tap_next = m ? bst_pkg::TAP_UP_IR  : bst_pkg::TAP_SH_IR;
      bst_pkg::TAP_UP_IR:  tap_next = m ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_IDLE;
      default:             tap_next = bst_pkg::TAP_RESET;
    endcase
  endfunction

  logic        rise;
  logic        fall;
  logic        sw;
  logic        dir_ok;
  logic        run_step;
  logic [35:0] oe_exp;
  logic [35:0] ov;
  logic [35:0] om;
  logic [35:0] op;
  logic [35:0] pin_m;
  logic [35:0] psa36;
  logic [17:0] sig18;
  logic [17:0] pat18;
  logic [35:0] nv;

  assign rise     = tck_s & ~r.tck_d;
  assign fall     = ~tck_s & r.tck_d;
  assign sw       = (r.dir == bst_pkg::DIR_B_IN);
  assign dir_ok   = (r.dir == bst_pkg::DIR_A_IN) || sw;
  assign run_step = rise && r.tap == bst_pkg::TAP_IDLE
                    && r.instr == bst_pkg::INSTR_RUN && dir_ok;
  assign oe_exp   = oe_expand(r.shadow);
  assign ov       = ord(r.chain[35:0], sw);
  assign om       = ord(oe_exp, sw);
  assign op       = ord(pin_s, sw);
  assign pin_m    = op & ~om;

  bst_lfsr_step #(.W(36), .TAPS(bst_pkg::TAPS36)) u_lfsr36 (
    .cur (ov),
    .din (pin_m),
    .nxt (psa36)
  );

  bst_lfsr_step #(.W(18), .TAPS(bst_pkg::TAPS18)) u_lfsr_sig (
    .cur (ov[17:0]),
    .din (pin_m[17:0]),
    .nxt (sig18)
  );

  bst_lfsr_step #(.W(18), .TAPS(bst_pkg::TAPS18)) u_lfsr_pat (
    .cur (ov[35:18]),
    .din ('0),
    .nxt (pat18)
  );

  // ----------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------
  always_comb begin
    case (r.opsel[1:0])
      bst_pkg::OPL_TOGGLE:    nv = (om & ~ov) | (~om & op);
      bst_pkg::OPL_PATTERN:   nv = psa36 ^ pin_m;
      bst_pkg::OPL_SIGNATURE: nv = psa36;
      default: begin
        if (r.opsel[bst_pkg::OPSEL_COUNT]) begin
          nv = {ov[35:18] + 18'h0_0001, sig18};
        end else begin
          nv = {pat18, sig18};
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r       = r;
    next_r.tck_d = tck_s;
    // Test port actions on rise use the state being left
    if (rise) begin
      next_r.tap = tap_next(r.tap, tms_s);
      case (r.tap)
        bst_pkg::TAP_CAP_IR: next_r.ir = bst_pkg::IR_CAPTURE;
        bst_pkg::TAP_SH_IR:  next_r.ir = {tdi_s, r.ir[7:1]};
        bst_pkg::TAP_CAP_DR: begin
          next_r.byp  = 1'b0;
          next_r.opsh = r.opsel;
        end
        bst_pkg::TAP_SH_DR: begin
          if (r.instr == bst_pkg::INSTR_BSCAN) begin
            next_r.chain = {tdi_s, r.chain[51:1]};
          end else if (r.instr == bst_pkg::INSTR_OPSCAN) begin
            next_r.opsh = {tdi_s, r.opsh[2:1]};
          end else begin
            next_r.byp = tdi_s;
          end
        end
        default: next_r.ran = 1'b0;
      endcase
    end
    // Only data cells move; control cells keep their scanned values
    if (run_step) begin
      next_r.chain[35:0] = ord(nv, sw);
      next_r.ran         = 1'b1;
    end
    // Outputs and latches change on fall
    if (fall) begin
      next_r.ran    = 1'b0;
      next_r.tdo_oe = (r.tap == bst_pkg::TAP_SH_IR) || (r.tap == bst_pkg::TAP_SH_DR);
      if (r.tap == bst_pkg::TAP_SH_IR) begin
        next_r.tdo = r.ir[0];
      end else if (r.instr == bst_pkg::INSTR_BSCAN) begin
        next_r.tdo = r.chain[0];
      end else if (r.instr == bst_pkg::INSTR_OPSCAN) begin
        next_r.tdo = r.opsh[0];
      end else begin
        next_r.tdo = r.byp;
      end
      if (r.tap == bst_pkg::TAP_UP_IR) begin
        next_r.instr = r.ir;
      end else if (r.tap == bst_pkg::TAP_RESET) begin
        next_r.instr = bst_pkg::INSTR_BYPASS;
      end
      if (r.tap == bst_pkg::TAP_UP_DR && r.instr == bst_pkg::INSTR_BSCAN) begin
        next_r.shadow = r.chain;
      end
      if (r.tap == bst_pkg::TAP_UP_DR && r.instr == bst_pkg::INSTR_OPSCAN) begin
        next_r.opsel = r.opsh;
      end
      // Signature-only run leaves the driven pattern where it was
      if (r.ran && r.opsel[1:0] != bst_pkg::OPL_SIGNATURE) begin
        next_r.shadow[35:0] = (r.shadow[35:0] & ~oe_exp) | (r.chain[35:0] & oe_exp);
      end
    end
    // Drive only under instructions that put the pins in test mode
    if (next_r.instr == bst_pkg::INSTR_RUN || next_r.instr == bst_pkg::INSTR_BSCAN) begin
      next_r.pin_oe = oe_expand(next_r.shadow);
    end else begin
      next_r.pin_oe = '0;
    end
    // APB, answer one cycle into the access phase
    next_r.pready  = psel & penable & ~r.pready;
    next_r.pslverr = 1'b0;
    if (psel && penable && !r.pready) begin
      case (paddr)
        bst_pkg::REG_CTRL: begin
          next_r.prdata = {28'h000_0000, r.dir};
          if (pwrite) begin
            next_r.dir = pwdata[3:0];
          end
        end
        bst_pkg::REG_STATUS:    next_r.prdata = {12'h000, dir_ok, r.opsel, r.instr,
                                                 3'h0, r.ran, r.tap};
        bst_pkg::REG_CHAIN_LO:  next_r.prdata = r.chain[31:0];
        bst_pkg::REG_CHAIN_HI:  next_r.prdata = {12'h000, r.chain[51:32]};
        bst_pkg::REG_SHADOW_LO: next_r.prdata = r.shadow[31:0];
        default: begin
          next_r.prdata  = 32'h0000_0000;
          next_r.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r         <= '0;
      r.tap     <= bst_pkg::TAP_RESET;
      r.instr   <= bst_pkg::INSTR_BYPASS;
      r.opsel   <= bst_pkg::OPSEL_RESET;
      r.chain   <= bst_pkg::CHAIN_RESET;
      r.shadow  <= bst_pkg::CHAIN_RESET;
      r.dir     <= bst_pkg::DIR_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign prdata  = r.prdata;
  assign pready  = r.pready;
  assign pslverr = r.pslverr;
  assign tdo     = r.tdo;
  assign tdo_oe  = r.tdo_oe;
  assign pin_out = r.shadow[35:0];
  assign pin_oe  = r.pin_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_step(logic [1:0] code);
    run_step && r.opsel[1:0] == code;
  endsequence

  property p_ir_capture;
    rise && r.tap == bst_pkg::TAP_CAP_IR |=> r.ir == bst_pkg::IR_CAPTURE;
  endproperty
  a_ir_capture: assert property (p_ir_capture) else $error("capture value wrong");
  property p_ir_shift;
    rise && r.tap == bst_pkg::TAP_SH_IR |=> r.ir[7] == $past(tdi_s);
  endproperty
  a_ir_shift: assert property (p_ir_shift) else $error("instruction shift lost tdi");
  property p_tdo_fall;
    !fall |=> $stable(tdo) && $stable(tdo_oe) && $stable(pin_out) && $stable(pin_oe);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("output moved off a fall");
  property p_toggle_out;
    s_step(bst_pkg::OPL_TOGGLE) |=>
      ((r.chain[35:0] ^ $past(r.chain[35:0])) & $past(oe_exp)) == $past(oe_exp);
  endproperty
  a_toggle_out: assert property (p_toggle_out) else $error("output cell not inverted");
  property p_toggle_in;
    s_step(bst_pkg::OPL_TOGGLE) |=>
      (r.chain[35:0] & ~$past(oe_exp)) == ($past(pin_s) & ~$past(oe_exp));
  endproperty
  a_toggle_in: assert property (p_toggle_in) else $error("input cell not sampled");
  property p_ctl_cells;
    run_step |=> r.chain[51:36] == $past(r.chain[51:36]);
  endproperty
  a_ctl_cells: assert property (p_ctl_cells) else $error("control cell changed");
  property p_sig_hold;
    fall && r.ran && r.opsel[1:0] == bst_pkg::OPL_SIGNATURE |=> $stable(r.shadow);
  endproperty
  a_sig_hold: assert property (p_sig_hold) else $error("shadow moved in signature");
  property p_count;
    run_step && r.opsel == 3'h7 |=> ov[35:18] == $past(ov[35:18]) + 18'h0_0001;
  endproperty
  a_count: assert property (p_count) else $error("count did not step by one");

  property p_idle_only;
    rise && r.instr == bst_pkg::INSTR_RUN && r.tap != bst_pkg::TAP_IDLE
      |=> $stable(r.chain);
  endproperty
  a_idle_only: assert property (p_idle_only) else $error("run outside idle");

  property p_mixed_dir;
    rise && r.tap == bst_pkg::TAP_IDLE && !dir_ok |=> $stable(r.chain) && !r.ran;
  endproperty
  a_mixed_dir: assert property (p_mixed_dir) else $error("run with mixed direction");

endmodule

/* bst_jtag_ctl.sv */
// Behavioural test port controller that walks the tap and scans registers
`timescale 1ns/100ps
module bst_jtag_ctl (
  // Clock
  input  wire logic sys_clk,
  // Test port
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // ----------------------------------------------------------------
  // One tck period of 8 sys_clk, entered at a sys_clk rise
  // ----------------------------------------------------------------
  // Tdo is taken just before the next fall, the only time it may move
  task automatic step(input logic m, input logic d, output logic t, output logic oe);
    tck <= 1'b0;
    @(posedge sys_clk);
    tms <= m;
    tdi <= d;
    repeat (3) @(posedge sys_clk);
    tck <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t  = tdo;
    oe = tdo_oe;
  endtask

  // Clock stands still low afterwards
  task automatic fall();
    tck <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask

  // Idle tdi shows the inverse of its last value
  task automatic start();
    logic t, oe;
    step(1'b0, ~tdi, t, oe);
  endtask

  task automatic ir_scan(input logic [7:0] code, output logic [7:0] cap, output logic ok);
    logic t, oe;
    ok = 1'b1;
    step(1'b1, ~tdi, t, oe);
    step(1'b1, ~tdi, t, oe);
    step(1'b0, ~tdi, t, oe);
    step(1'b0, ~tdi, t, oe);
    for (int i = 0; i < 8; i++) begin
      step(i == 7, code[i], t, oe);
      cap[i] = t;
      ok &= (oe === 1'b1);
    end
    step(1'b1, ~tdi, t, oe);
    ok &= (oe === 1'b0);
  endtask

  task automatic dr_scan(input int n, input logic [51:0] data, output logic [51:0] q);
    logic t, oe;
    q = '0;
    step(1'b1, ~tdi, t, oe);
    step(1'b0, ~tdi, t, oe);
    step(1'b0, ~tdi, t, oe);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, data[i], t, oe);
      q[i] = t;
    end
    step(1'b1, ~tdi, t, oe);
  endtask

  // Enter idle, give k rises there, then one closing fall
  task automatic run(input int k);
    logic t, oe;
    for (int i = 0; i <= k; i++) begin
      step(1'b0, ~tdi, t, oe);
    end
    fall();
  endtask
endmodule

/* boundary_scan_test_operations_tb.sv */
// Self-checking bench for the boundary test operations block
`timescale 1ns/100ps
module boundary_scan_test_operations_tb;
  logic        sys_clk;
  logic        rst_n;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tdo_oe;
  logic [35:0] pin_in;
  logic [35:0] pin_out;
  logic [35:0] pin_oe;
  logic [35:0] ext;
  logic [31:0] rd;
  logic        er;
  int          err_count;
  int          n_checks;

  // Driven pins read back their own value
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

  bst_top dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
  );
  bst_jtag_ctl ctl_u (
    .sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [51:0] got, input logic [51:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      end_of_test();
    end else begin
      r       = prdata;
      e       = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask

  function automatic logic [35:0] l36(input logic [35:0] c, input logic [35:0] d);
    return {c[34:0], ^(c & bst_pkg::TAPS36)} ^ d;
  endfunction

  function automatic logic [17:0] l18(input logic [17:0] c, input logic [17:0] d);
    return {c[16:0], ^(c & bst_pkg::TAPS18)} ^ d;
  endfunction

  // Halves swap when the B side feeds in
  function automatic logic [35:0] sw36(input logic [35:0] c, input logic s);
    return s ? {c[17:0], c[35:18]} : c;
  endfunction

  // ----------------------------------------------------------------
  // Select, seed, run k idle rises, compare chain, pins and status
  // ----------------------------------------------------------------
  task automatic run_case(input logic [3:0] dir, input logic [2:0] op, input int k);
    logic [7:0]  cap;
    logic        ok;
    logic        vd;
    logic [51:0] q;
    logic [51:0] seed;
    logic [3:0]  oe;
    logic [35:0] om;
    logic [35:0] v;
    logic [17:0] lo;
    logic [17:0] hi;
    logic        sb;
    logic [35:0] oa;
    logic [35:0] xa;
    logic [35:0] sh;
    oe   = (dir == 4'hF) ? 4'hC : dir;
    seed = {oe, 12'h5A3, 36'h9_1234_ABCD};
    om   = {{9{oe[3]}}, {9{oe[2]}}, {9{oe[1]}}, {9{oe[0]}}};
    vd   = (dir == bst_pkg::DIR_A_IN) || (dir == bst_pkg::DIR_B_IN);
    do_reset();
    apb(1'b1, bst_pkg::REG_CTRL, {28'h0, dir}, rd, er);
    ctl_u.start();
    ctl_u.ir_scan(bst_pkg::INSTR_OPSCAN, cap, ok);
    chk(cap, bst_pkg::IR_CAPTURE);
    chk(ok, 1'b1);
    ctl_u.dr_scan(3, {49'h0, op}, q);
    chk(q[2:0], bst_pkg::OPSEL_RESET);
    ctl_u.ir_scan(bst_pkg::INSTR_BSCAN, cap, ok);
    ctl_u.dr_scan(52, seed, q);
    ctl_u.ir_scan(bst_pkg::INSTR_RUN, cap, ok);
    ctl_u.run(k);
    // Model steps the arranged vector, as the cells do
    sb = (dir == bst_pkg::DIR_B_IN);
    v  = sw36(seed[35:0], sb);
    oa = sw36(om, sb);
    xa = sw36(ext, sb) & ~oa;
    for (int i = 0; i < k && vd; i++) begin
      lo = l18(v[17:0], xa[17:0]);
      hi = op[2] ? v[35:18] + 18'h1 : l18(v[35:18], 18'h0);
      case (op[1:0])
        2'h0:    v = (~v & oa) | xa;
        2'h1:    v = l36(v, 36'h0);
        2'h2:    v = l36(v, xa);
        default: v = {hi, lo};
      endcase
    end
    v  = sw36(v, sb);
    sh = (op[1:0] == 2'h2 || !vd) ? seed[35:0] : (v & om) | (seed[35:0] & ~om);
    chk(pin_oe, om);
    chk(pin_out, sh);
    q = {seed[51:36], v};
    apb(1'b0, bst_pkg::REG_CHAIN_LO, 32'h0, rd, er);
    chk(rd, q[31:0]);
    apb(1'b0, bst_pkg::REG_CHAIN_HI, 32'h0, rd, er);
    chk(rd[19:0], q[51:32]);
    apb(1'b0, bst_pkg::REG_STATUS, 32'h0, rd, er);
    chk({rd[19:8], rd[3:0]}, {vd, op, bst_pkg::INSTR_RUN, bst_pkg::TAP_IDLE});
    apb(1'b0, bst_pkg::REG_SHADOW_LO, 32'h0, rd, er);
    chk(rd, sh[31:0]);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n     = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0000_0000;
    ext       = 36'hA_5C3E_1B27;
    err_count = 0;
    n_checks  = 0;
    do_reset();
    chk({tdo_oe, pin_oe}, 37'h0);
    apb(1'b1, bst_pkg::REG_STATUS, 32'hFFFF_FFFF, rd, er);
    chk(er, 1'b0);
    apb(1'b0, bst_pkg::REG_STATUS, 32'h0, rd, er);
    chk({rd[19:8], rd[4:0]}, {1'b0, bst_pkg::OPSEL_RESET, bst_pkg::INSTR_BYPASS, 5'h00});
    apb(1'b1, bst_pkg::REG_CTRL, 32'h0000_0005, rd, er);
    apb(1'b0, bst_pkg::REG_CTRL, 32'h0, rd, er);
    chk(rd[3:0], 4'h5);
    apb(1'b0, 8'h20, 32'h0, rd, er);
    chk({er, rd}, {1'b1, 32'h0000_0000});
    apb(1'b1, 8'h24, 32'h1234_5678, rd, er);
    chk(er, 1'b1);
    run_case(4'hC, 3'h4, 3);
    run_case(4'h3, 3'h0, 2);
    run_case(4'hC, 3'h1, 5);
    run_case(4'hC, 3'h6, 4);
    run_case(4'hC, 3'h3, 4);
    run_case(4'hC, 3'h7, 4);
    run_case(4'h3, 3'h3, 4);
    run_case(4'h3, 3'h2, 3);
    run_case(4'hF, 3'h0, 3);
    end_of_test();
  end
endmodule
